/* design/dsp_pkg.sv */
// package for the data/strobe serdes phy: register map, field positions,
// reset values and link timing figures.
// assumes a 32-bit classic wishbone bus and a 10 MHz system clock.
package dsp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;  // link control
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;  // link status

  // control fields
  localparam int unsigned CTRL_DRIVE_BIT  = 0;      // transmit drive enable
  localparam int unsigned CTRL_LOCAL_BIT  = 1;      // local loop enable
  localparam int unsigned CTRL_REMOTE_BIT = 2;      // remote loop enable
  localparam int unsigned CTRL_RUN_BIT    = 3;      // link out of reset
  localparam int unsigned CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  // status fields
  localparam int unsigned STAT_EVEN_BIT   = 0;      // last even bit shown
  localparam int unsigned STAT_ODD_BIT    = 1;      // last odd bit shown
  localparam int unsigned STAT_DRIVE_BIT  = 2;      // transmitter driving
  localparam int unsigned STAT_RXOE_BIT   = 3;      // receive outputs driven
  localparam int unsigned STAT_W          = 4;

  // ---------------------------------------------------------------
  // link timing
  // ---------------------------------------------------------------
  localparam int unsigned MAX_BIT_RATE_MBPS = 200;  // fastest serial rate
  localparam int unsigned LINK_RESET_CYCLES = 3;    // least hold of link reset
  localparam int unsigned SYNC_STAGES       = 2;

  // serializer half of the word being sent
  typedef enum logic {
    DSP_PH_EVEN,
    DSP_PH_ODD
  } dsp_phase_e;

endpackage

/* design/dsp_serdes_phy.sv */
// data/strobe link serdes phy: two-bit serializer and both-edge receiver,
// with local and remote loopback and a tristatable transmitter.
// assumes a classic wishbone master on clk, a controller that makes the
// bit and word clocks from one source, and a cable model that resolves
// the differential pins from the output enables.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module dsp_serdes_phy
  import dsp_pkg::*;
(
  input  wire  logic              clk,              // system clock, 10 MHz
  input  wire  logic              rst_n,            // async reset, active low
  input  wire  logic              wb_cyc_i,         // bus cycle
  input  wire  logic              wb_stb_i,         // bus strobe
  input  wire  logic              wb_we_i,          // write enable
  input  wire  logic [ADDR_W-1:0] wb_adr_i,         // byte address
  input  wire  logic [3:0]        wb_sel_i,         // byte lanes
  input  wire  logic [31:0]       wb_dat_i,         // write data
  output logic       [31:0]       wb_dat_o,         // read data
  output logic                    wb_ack_o,         // acknowledge
  input  wire  logic              txBitClock,       // serial bit clock
  input  wire  logic              txWordClock,      // pair clock, half rate
  input  wire  logic              txDataEven,       // first data bit of pair
  input  wire  logic              txDataOdd,        // second data bit of pair
  input  wire  logic              txStrobeEven,     // first strobe bit of pair
  input  wire  logic              txStrobeOdd,      // second strobe bit of pair
  output logic                    txDataP,          // line data, positive
  output logic                    txDataN,          // line data, negative
  output logic                    txStrobeP,        // line strobe, positive
  output logic                    txStrobeN,        // line strobe, negative
  output logic                    txDriveOe,        // transmit pins driven
  input  wire  logic              rxDataP,          // received data, positive
  input  wire  logic              rxDataN,          // received data, negative
  input  wire  logic              rxStrobeP,        // received strobe, positive
  input  wire  logic              rxStrobeN,        // received strobe, negative
  output logic                    rxEvenBit,        // even bit of received pair
  output logic                    rxOddBit,         // odd bit of received pair
  output logic                    recoveredRxClock, // data xor strobe
  output logic                    rxOutOe           // receive outputs driven
);

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  // differential receiver: equal legs read high, as the fail-safe bias does
  function automatic logic diffRx(input logic pos, input logic neg);
    diffRx = (pos != neg) ? pos : 1'b1;
  endfunction

  // control address decode, shared by the read and the write path
  function automatic logic hitCtrl(input logic [ADDR_W-1:0] adr);
    hitCtrl = (adr == CTRL_OFFSET);
  endfunction

  // status address decode
  function automatic logic hitStatus(input logic [ADDR_W-1:0] adr);
    hitStatus = (adr == STATUS_OFFSET);
  endfunction

  // reset values of the internal registers; unmapped reads show zero, idle read data holds what the last read or write request loaded
  localparam logic [31:0]       RDATA_RESET = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STAT_RESET  = 4'h0;
  localparam logic [4:0]        PINS_RESET  = 5'h00;
  localparam logic [3:0]        PAIR_RESET  = 4'h0;

  // ---------------------------------------------------------------
  // register bus (clk domain)
  // ---------------------------------------------------------------
  logic              ack_reg;
  logic              ack_next;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [STAT_W-1:0] statSync1_reg;
  logic [STAT_W-1:0] statSync2_reg;
  logic [STAT_W-1:0] statRaw;
  logic              busReq;
  logic              ctrlFlip_reg;   // flips on every landed control write
  logic              ctrlFlip_next;
  logic              ctrlWrite;      // a control write lands on this edge

  assign busReq   = wb_cyc_i & wb_stb_i;
  assign ctrlWrite = busReq & ack_reg & wb_we_i & wb_sel_i[0] & hitCtrl(wb_adr_i);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // one-wait-state answer; read data is loaded on the taking edge so that
  // it stands when ack is sampled, and a write lands on the acknowledged
  // edge, the only edge at which the master surely still holds its data
  always_comb begin
    ack_next      = busReq & ~ack_reg;
    rdata_next    = rdata_reg;
    ctrl_next     = ctrl_reg;
    ctrlFlip_next = ctrlFlip_reg;
    if (busReq && !ack_reg) begin
      rdata_next = RDATA_RESET;                         // unmapped reads zero
      if (hitCtrl(wb_adr_i)) begin
        rdata_next[CTRL_W-1:0] = ctrl_reg;
      end else if (hitStatus(wb_adr_i)) begin
        rdata_next[STAT_W-1:0] = statSync2_reg;
      end
    end
    if (ctrlWrite) begin
      ctrl_next     = wb_dat_i[CTRL_W-1:0];
      ctrlFlip_next = ~ctrlFlip_reg;                    // tell the link side
    end
  end

  // bus state registers; ack clears itself the cycle after it rose, so a
  // request that is still held on the ack edge is answered only once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg       <= 1'b0;
      rdata_reg     <= RDATA_RESET;
      ctrl_reg      <= CTRL_RESET;
      ctrlFlip_reg  <= 1'b0;
      statSync1_reg <= STAT_RESET;
      statSync2_reg <= STAT_RESET;
    end else begin
      ack_reg       <= ack_next;
      rdata_reg     <= rdata_next;
      ctrl_reg      <= ctrl_next;
      ctrlFlip_reg  <= ctrlFlip_next;
      statSync1_reg <= statRaw;
      statSync2_reg <= statSync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // bit clock domain: control and pin synchronisers
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrlLink_reg;   // control word as the link uses it
  logic [CTRL_W-1:0] ctrlLink_next;
  logic              flipSync1_reg;  // write flag, first stage
  logic              flipSync2_reg;  // write flag, second stage
  logic              flipPrev_reg;
  logic              ctrlArrive;     // a new control word waits in clk domain
  logic [4:0]        pinSync1_reg;   // word clock and tx pair
  logic [4:0]        pinSync2_reg;
  logic              wordPrev_reg;
  logic              driveEn;
  logic              localLoop;
  logic              remoteLoop;
  logic              linkRun;
  logic              wordRise;

  // control fields as the link applies them
  assign driveEn    = ctrlLink_reg[CTRL_DRIVE_BIT];
  assign localLoop  = ctrlLink_reg[CTRL_LOCAL_BIT];
  assign remoteLoop = ctrlLink_reg[CTRL_REMOTE_BIT];
  assign linkRun    = ctrlLink_reg[CTRL_RUN_BIT];
  assign ctrlArrive = flipSync2_reg ^ flipPrev_reg;
  assign wordRise   = pinSync2_reg[4] & ~wordPrev_reg;

  // two flops on the write flag and on every pin entering the bit clock
  // domain; the control word itself is not synchronised bit by bit, since
  // its bits could then arrive on different edges and mix two settings
  always_ff @(posedge txBitClock or negedge rst_n) begin
    if (!rst_n) begin
      flipSync1_reg <= 1'b0;
      flipSync2_reg <= 1'b0;
      flipPrev_reg  <= 1'b0;
      pinSync1_reg  <= PINS_RESET;
      pinSync2_reg  <= PINS_RESET;
      wordPrev_reg  <= 1'b0;
    end else begin
      flipSync1_reg <= ctrlFlip_reg;
      flipSync2_reg <= flipSync1_reg;
      flipPrev_reg  <= flipSync2_reg;
      pinSync1_reg  <= {txWordClock, txStrobeOdd, txStrobeEven, txDataOdd, txDataEven};
      pinSync2_reg  <= pinSync1_reg;
      wordPrev_reg  <= pinSync2_reg[4];
    end
  end

  // take the whole control word once its flag has crossed; ctrl_reg has
  // then stood still for two bit clock edges, and the next write is at
  // least two clk cycles away, far longer than the crossing takes
  always_comb begin
    ctrlLink_next = ctrlLink_reg;
    if (ctrlArrive) begin
      ctrlLink_next = ctrl_reg;
    end
  end

  // control word register of the link side
  always_ff @(posedge txBitClock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlLink_reg <= CTRL_RESET;
    end else begin
      ctrlLink_reg <= ctrlLink_next;
    end
  end

  // ---------------------------------------------------------------
  // serializer (bit clock domain)
  // ---------------------------------------------------------------
  dsp_phase_e phase_reg;
  dsp_phase_e phase_next;
  logic [3:0] pair_reg;              // {sOdd, sEven, dOdd, dEven}
  logic [3:0] pair_next;
  logic       serData_reg;
  logic       serData_next;
  logic       serStrobe_reg;
  logic       serStrobe_next;
  logic       tx_drive_enable_reg;
  logic       tx_drive_enable_next;
  logic       rxOe_reg;
  logic       rxOe_next;

  // word edge loads the pair and sends its even bit, odd follows; one bit
  // leaves on every rising bit clock edge with no divider or gap, so the line runs
  // at the full bit clock rate, up to MAX_BIT_RATE_MBPS
  always_comb begin
    phase_next     = phase_reg;
    pair_next      = pair_reg;
    serData_next   = serData_reg;
    serStrobe_next = serStrobe_reg;
    if (wordRise) begin
      pair_next      = pinSync2_reg[3:0];
      serData_next   = pinSync2_reg[0];
      serStrobe_next = pinSync2_reg[2];
      phase_next     = DSP_PH_ODD;
    end else begin
      case (phase_reg)
        DSP_PH_ODD: begin
          serData_next   = pair_reg[1];
          serStrobe_next = pair_reg[3];
          phase_next     = DSP_PH_EVEN;
        end
        DSP_PH_EVEN: begin
          phase_next = DSP_PH_EVEN;
        end
        default: begin
          phase_next = DSP_PH_EVEN;
        end
      endcase
    end
    if (!linkRun) begin
      serData_next   = 1'b0;
      serStrobe_next = 1'b0;
      phase_next     = DSP_PH_EVEN;
    end
    tx_drive_enable_next = driveEn;
    rxOe_next = linkRun;
  end

  // serializer state
  always_ff @(posedge txBitClock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg     <= DSP_PH_EVEN;
      pair_reg      <= PAIR_RESET;
      serData_reg   <= 1'b0;
      serStrobe_reg <= 1'b0;
      tx_drive_enable_reg      <= 1'b0;
      rxOe_reg      <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      pair_reg      <= pair_next;
      serData_reg   <= serData_next;
      serStrobe_reg <= serStrobe_next;
      tx_drive_enable_reg      <= tx_drive_enable_next;
      rxOe_reg      <= rxOe_next;
    end
  end

  // ---------------------------------------------------------------
  // line receiver and recovered clock domain
  // ---------------------------------------------------------------
  logic lineData;
  logic lineStrobe;
  logic rxRise_reg;
  logic rxFall_reg;

  assign lineData         = diffRx(rxDataP, rxDataN);
  assign lineStrobe       = diffRx(rxStrobeP, rxStrobeN);
  assign recoveredRxClock = lineData ^ lineStrobe;

  // the recovered clock is a clock of its own: line data has settled
  // before each of its edges, so no synchroniser sits in front of these
  // rising edge bit is the even one
  always_ff @(posedge recoveredRxClock or negedge rst_n) begin
    if (!rst_n) begin
      rxRise_reg <= 1'b0;
    end else begin
      rxRise_reg <= lineData;
    end
  end

  // falling edge bit is the odd one
  always_ff @(negedge recoveredRxClock or negedge rst_n) begin
    if (!rst_n) begin
      rxFall_reg <= 1'b0;
    end else begin
      rxFall_reg <= lineData;
    end
  end

  // ---------------------------------------------------------------
  // output steering
  // ---------------------------------------------------------------
  logic txLineData;
  logic txLineStrobe;

  // received pair or local loop of the controller's pair; the loop shows
  // the pair the serializer last loaded, the bits that leave on the line when the link runs without remote loop
  assign rxEvenBit = localLoop ? pair_reg[0] : rxRise_reg;
  assign rxOddBit  = localLoop ? pair_reg[1] : rxFall_reg;
  assign rxOutOe   = rxOe_reg;

  // remote loop resends the line, even while the link is held in reset
  assign txLineData   = remoteLoop ? lineData : serData_reg;
  assign txLineStrobe = remoteLoop ? lineStrobe : serStrobe_reg;
  assign txDataP      = txLineData;
  assign txDataN      = ~txLineData;
  assign txStrobeP    = txLineStrobe;
  assign txStrobeN    = ~txLineStrobe;
  assign txDriveOe    = tx_drive_enable_reg;

  // status seen by software, synchronised into clk above; the two enable bits
  // are slow levels that stand for many clk cycles, the even and odd bits can
  // change every bit time, and each bit means something on its own, so a torn
  // sample only mixes an older and a newer view of independent flags and settles on the next clk edge
  assign statRaw = {rxOe_reg, tx_drive_enable_reg, rxOddBit, rxEvenBit};

endmodule

`default_nettype wire

/* tb/dsp_serdes_phy_chk.sv */
// checker for the serdes phy: bus answer, drive, loop and receive steering.
// assumes a bind to the phy top; control is mirrored from bus writes.
`timescale 1ns/10ps
`default_nettype none
module dsp_serdes_phy_chk
  import dsp_pkg::*;
(
  input wire logic              clk,              // system clock
  input wire logic              rst_n,            // async reset
  input wire logic              wb_cyc_i,         // bus cycle
  input wire logic              wb_stb_i,         // bus strobe
  input wire logic              wb_we_i,          // write enable
  input wire logic [ADDR_W-1:0] wb_adr_i,         // byte address
  input wire logic [3:0]        wb_sel_i,         // byte lanes
  input wire logic [31:0]       wb_dat_i,         // write data
  input wire logic [31:0]       wb_dat_o,         // read data
  input wire logic              wb_ack_o,         // acknowledge
  input wire logic              txDataP,          // line data out
  input wire logic              txDataN,          // line data out, neg
  input wire logic              txDriveOe,        // transmit driven
  input wire logic              rxDataP,          // line data in
  input wire logic              rxDataN,          // line data in, neg
  input wire logic              rxStrobeP,        // line strobe in
  input wire logic              rxStrobeN,        // line strobe in, neg
  input wire logic              recoveredRxClock, // data xor strobe
  input wire logic              rxOutOe           // receive driven
);
  // ------------------------------------------------------------
  // control mirror and line levels
  // ------------------------------------------------------------
  logic [3:0] ctrlReg;
  logic [3:0] ctrlNext;
  logic       lineData;
  logic       lineStrobe;
  // equal pins read as high, like the fail-safe receiver
  assign lineData   = (rxDataP != rxDataN) ? rxDataP : 1'b1;
  assign lineStrobe = (rxStrobeP != rxStrobeN) ? rxStrobeP : 1'b1;
  // a write lands at the edge where the master sees ack
  always_comb begin
    ctrlNext = ctrlReg;
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFFSET)
      ctrlNext = wb_dat_i[3:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ctrlReg <= CTRL_RESET;
    else
      ctrlReg <= ctrlNext;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_run_held;
    ctrlReg[CTRL_RUN_BIT] [*2];
  endsequence
  a_ack_after_req: assert property (@(posedge clk) disable iff (!rst_n)
    s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o && !wb_we_i && wb_adr_i != CTRL_OFFSET && wb_adr_i != STATUS_OFFSET
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_rx_oe_run: assert property (@(posedge clk) disable iff (!rst_n)
    s_run_held |-> rxOutOe) else $error("receive outputs not driven");
  a_rx_oe_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrlReg[CTRL_RUN_BIT]) [*2] |-> !rxOutOe) else $error("receive driven in link reset");
  a_drive_follow: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(ctrlReg) |-> txDriveOe == ctrlReg[CTRL_DRIVE_BIT]) else $error("drive enable wrong");
  a_tx_zero_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrlReg[CTRL_DRIVE_BIT] && !ctrlReg[CTRL_RUN_BIT] && !ctrlReg[CTRL_REMOTE_BIT]) [*2]
    |-> !txDataP) else $error("transmit not zero in link reset");
  a_remote_pass: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrlReg[CTRL_DRIVE_BIT] && ctrlReg[CTRL_REMOTE_BIT]) [*2] |-> txDataP == lineData)
    else $error("remote loop not passing line");
  a_tx_diff: assert property (@(posedge clk) disable iff (!rst_n)
    txDriveOe |-> txDataN == !txDataP) else $error("transmit pair not complementary");
  a_rx_clk_xor: assert property (@(posedge clk) disable iff (!rst_n)
    recoveredRxClock == (lineData ^ lineStrobe)) else $error("recovered clock wrong");
endmodule
`default_nettype wire

/* tb/dsp_ctrl_model.sv */
// link controller model: word clock at half the bit clock, pairs on it.
// assumes the bench supplies the bit clock and the pair to send.
`timescale 1ns/10ps
`default_nettype none
module dsp_ctrl_model (
  input  wire logic       txBitClock,   // bit clock from bench
  input  wire logic       rst_n,        // reset, active low
  input  wire logic [3:0] pairIn,       // strobe odd/even, data odd/even
  output logic            txWordClock,  // half rate word clock
  output logic            txDataEven,   // first data bit
  output logic            txDataOdd,    // second data bit
  output logic            txStrobeEven, // first strobe bit
  output logic            txStrobeOdd   // second strobe bit
);
  logic       wordReg;
  logic [3:0] pairReg;
  // word clock divides the one bit clock; pair moves on its rising edge
  always_ff @(posedge txBitClock or negedge rst_n) begin
    if (!rst_n) begin
      wordReg <= 1'b0;
      pairReg <= 4'h0;
    end else begin
      wordReg <= ~wordReg;
      if (!wordReg)
        pairReg <= pairIn;
    end
  end
  // index 0 is the even bit, sent first
  assign txWordClock  = wordReg;
  assign txDataEven   = pairReg[0];
  assign txDataOdd    = pairReg[1];
  assign txStrobeEven = pairReg[2];
  assign txStrobeOdd  = pairReg[3];
endmodule
`default_nettype wire

/* tb/dsp_serdes_phy_tb_top.sv */
// bench top: bus master, cable driver and link clock around the phy.
// assumes the controller model beside it and the checker bound below.
`timescale 1ns/10ps
`default_nettype none
module dsp_serdes_phy_tb_top;
  import dsp_pkg::*;
  logic        clk = 0, rst_n = 0, txBitClock = 0, cyc = 0, stb = 0, we = 0;
  logic        rxDP = 0, rxDN = 1, rxSP = 0, rxSN = 1, dLine = 0, sLine = 0, bE, bO;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, pairIn = 0, ctrl;
  logic [31:0] datW = 0, datR, rd;
  logic        ack, txWord, tDE, tDO, tSE, tSO, tDP, tDN, tSP, tSN, tOe, rxE, rxO, rClk, rOe;
  int          errTotal = 0, checksDone = 0, cycles = 0;
  dsp_ctrl_model dsp_ctrl_model_i (.txBitClock(txBitClock), .rst_n(rst_n), .pairIn(pairIn),
    .txWordClock(txWord), .txDataEven(tDE), .txDataOdd(tDO), .txStrobeEven(tSE),
    .txStrobeOdd(tSO));
  dsp_serdes_phy dsp_serdes_phy_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .txBitClock(txBitClock), .txWordClock(txWord), .txDataEven(tDE),
    .txDataOdd(tDO), .txStrobeEven(tSE), .txStrobeOdd(tSO), .txDataP(tDP), .txDataN(tDN),
    .txStrobeP(tSP), .txStrobeN(tSN), .txDriveOe(tOe), .rxDataP(rxDP), .rxDataN(rxDN),
    .rxStrobeP(rxSP), .rxStrobeN(rxSN), .rxEvenBit(rxE), .rxOddBit(rxO),
    .recoveredRxClock(rClk), .rxOutOe(rOe));
  // ------------------------------------------------------------
  // clocks and hang guard
  // ------------------------------------------------------------
  always #50 clk = ~clk;
  initial begin
    #1.7;
    forever #3 txBitClock = ~txBitClock;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      endSim();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // classic cycle held until ack is sampled high
  task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, datW, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = datR;
    {cyc, stb} <= 2'b00;
  endtask
  // data/strobe coding: strobe flips when data repeats
  task automatic sendBit(input logic b);
    @(posedge clk);
    sLine = (b == dLine) ? ~sLine : sLine;
    dLine = b;
    {rxDP, rxDN, rxSP, rxSN} <= {b, ~b, sLine, ~sLine};
  endtask
  // after a word clock fall the even bit is on the line
  task automatic checkSer();
    logic [1:0] e;
    repeat (12) @(negedge txBitClock);
    repeat (4) begin
      @(negedge txBitClock);
      e = txWord ? {pairIn[3], pairIn[1]} : {pairIn[2], pairIn[0]};
      cmp("serial", 32'(e), 32'({tSP, tDP}));
      cmp("serial neg", 32'(e ^ 2'b11), 32'({tSN, tDN}));
    end
  endtask
  task automatic endSim();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence: every control code, then bus corners
  // ------------------------------------------------------------
  initial begin
    rd = $urandom(84);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int c = 0; c < 16; c++) begin
      ctrl = 4'(c);
      wbXfer(1'b1, CTRL_OFFSET, 32'(c), 4'h1, rd);
      wbXfer(1'b0, CTRL_OFFSET, 32'h0, 4'hf, rd);
      cmp("ctrl", 32'(c), rd);
      pairIn <= 4'($urandom);
      repeat (2) begin
        bE = 1'($urandom);
        bO = 1'($urandom);
        sendBit(bE);
        sendBit(bO);
        @(negedge clk);
        if (ctrl[CTRL_RUN_BIT] && !ctrl[CTRL_LOCAL_BIT]) begin
          cmp("rx even", 32'(bE), 32'(rxE));
          cmp("rx odd", 32'(bO), 32'(rxO));
        end
        if (ctrl[CTRL_REMOTE_BIT])
          cmp("remote", 32'({sLine, dLine}), 32'({tSP, tDP}));
      end
      if (ctrl[CTRL_RUN_BIT] && ctrl[CTRL_LOCAL_BIT]) begin
        cmp("loop even", 32'(pairIn[0]), 32'(rxE));
        cmp("loop odd", 32'(pairIn[1]), 32'(rxO));
      end
      if (ctrl[CTRL_RUN_BIT] && ctrl[CTRL_DRIVE_BIT] && !ctrl[CTRL_REMOTE_BIT])
        checkSer();
    end
    wbXfer(1'b1, CTRL_OFFSET, 32'h0, 4'h0, rd);
    wbXfer(1'b0, CTRL_OFFSET, 32'h0, 4'hf, rd);
    cmp("ctrl lane off", 32'hf, rd);
    wbXfer(1'b0, 8'h08, 32'h0, 4'hf, rd);
    cmp("unmapped", 32'h0, rd);
    wbXfer(1'b1, CTRL_OFFSET, 32'h9, 4'h1, rd);
    sendBit(1'b1);
    sendBit(1'b0);
    repeat (4) @(posedge clk);
    wbXfer(1'b0, STATUS_OFFSET, 32'h0, 4'hf, rd);
    cmp("status", 32'hd, rd);
    endSim();
  end
endmodule
bind dsp_serdes_phy dsp_serdes_phy_chk dsp_serdes_phy_chk_i (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .txDataP(txDataP), .txDataN(txDataN), .txDriveOe(txDriveOe), .rxDataP(rxDataP),
  .rxDataN(rxDataN), .rxStrobeP(rxStrobeP), .rxStrobeN(rxStrobeN),
  .recoveredRxClock(recoveredRxClock), .rxOutOe(rxOutOe));
`default_nettype wire
